// ### uogc_pkg.sv
// Package for the OTG global configuration and event block.
// Assumes a single ref_clk domain; uogc_top, the checker and the bench import it whole.
`default_nettype none
package uogc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] UOGC_OTG_CTL_OFS  = 12'h000;
    localparam logic [11:0] UOGC_EVENT_OFS    = 12'h004;
    localparam logic [11:0] UOGC_BUS_CFG_OFS  = 12'h008;
    localparam logic [11:0] UOGC_LINK_CFG_OFS = 12'h00C;
    localparam logic [11:0] UOGC_PHY_EVT_OFS  = 12'h010;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int UOGC_SESS_OK_BIT    = 0;
    localparam int UOGC_SESS_REQ_BIT   = 1;
    localparam int UOGC_SWAP_OK_BIT    = 8;
    localparam int UOGC_SWAP_REQ_BIT   = 9;
    localparam int UOGC_EV_CHARGER     = 20;
    localparam int UOGC_EV_DEBOUNCE    = 19;
    localparam int UOGC_EV_A_TIMEOUT   = 18;
    localparam int UOGC_EV_SWAP_SEEN   = 17;
    localparam int UOGC_EV_SWAP_RES    = 9;
    localparam int UOGC_EV_SESS_RES    = 8;
    localparam int UOGC_EV_SESS_END    = 2;
    localparam int UOGC_NOTIFY_BIT     = 22;
    localparam int UOGC_REMOTE_BIT     = 21;
    localparam int UOGC_PER_LVL_BIT    = 8;
    localparam int UOGC_NPER_LVL_BIT   = 7;
    localparam int UOGC_DMA_BIT        = 5;
    localparam int UOGC_BURST_LSB      = 1;
    localparam int UOGC_UNMASK_BIT     = 0;
    localparam int UOGC_FORCE_DEV_BIT  = 30;
    localparam int UOGC_FORCE_HOST_BIT = 29;
    localparam int UOGC_PULL_DET_BIT   = 27;
    localparam int UOGC_VBUS_INV_BIT   = 23;
    localparam int UOGC_PULSE_SEL_BIT  = 22;
    localparam int UOGC_EXT_CMP_BIT    = 21;
    localparam int UOGC_HNP_CAP_BIT    = 9;
    localparam int UOGC_SRP_CAP_BIT    = 8;

    // ------------------------------------------------------------
    // Masks, reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] UOGC_EVENT_MASK  = 32'h001E_0304;
    localparam logic [31:0] UOGC_BUS_MASK    = 32'h0060_01BF;
    localparam logic [31:0] UOGC_LINK_MASK   = 32'h68E0_0300;
    localparam logic [31:0] UOGC_REG_RESET   = 32'h0000_0000;
    localparam int          UOGC_CLK_HZ      = 20_000_000;
    localparam int          UOGC_FORCE_MS    = 25;
    localparam int          UOGC_FORCE_CYC   = UOGC_CLK_HZ / 1000 * UOGC_FORCE_MS;
    localparam logic [3:0]  UOGC_BURST_MAX   = 4'h7;

    typedef enum logic [2:0] {
        UOGC_DMA_IDLE = 3'b001,
        UOGC_DMA_REQ  = 3'b010,
        UOGC_DMA_WAIT = 3'b100
    } uogc_dma_state_t;
endpackage
`default_nettype wire

// ### uogc_sync.sv
// Two-flop synchroniser bank for pins from outside ref_clk.
// Assumes inputs are asynchronous levels; first flop is read only by the second.
`default_nettype none
module uogc_sync #(
    parameter int W = 8
) (
    // Clock and control
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } uogc_sync_t;

    uogc_sync_t s_r;
    uogc_sync_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = d_async;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign q_sync = s_r.sync;
endmodule
`default_nettype wire

// ### uogc_top.sv
// OTG global configuration, OTG event flags and DMA write notification.
// Assumes a plain register port on ref_clk and PHY pins asynchronous to it.
//
// Summary of operation
// - Session request success status set on success, cleared on failure.
// - Charger pin change sets bit 20 only when charger support is built.
// - Connect debounce done sets bit 19 only with swap or session capability.
// - A-role connect timeout sets bit 18.
// - Role swap request seen on the bus sets bit 17.
// - Role swap result sets bit 9; software reads the ok status.
// - Session request result sets bit 8; software reads the ok status.
// - Falling B-session valid from the PHY sets bit 2.
// - With remote memory, bit 22 chooses notifying every write or last only.
// - Bit 21 enables request, done and system done wait before completion.
// - Bit 8 picks half or full empty for periodic FIFO trigger.
// - Bit 7 picks half or full empty for non-periodic FIFO trigger.
// - Bit 5 selects DMA mode; reads zero on slave-only builds.
// - External DMA drives burst field on burst output; codes above 7 reserved.
// - Internal DMA uses same field as bus burst type code.
// - Bit 0 gates the interrupt line; status keeps updating regardless.
// - Bit 30 forces device role after 25 ms; only for modes 0 to 2.
// - Bit 29 forces host role after 25 ms; only for modes 0 to 2.
// - Bit 27 detaches pull resistors during traffic when inter-chip USB capable.
// - Bit 23 tells PHY to invert external VBUS indicator.
// - Bit 22 picks transmit-valid or termination-select for SRP pulsing.
// - Bit 21 picks external VBUS comparator for ULPI builds 2 or 3.
`default_nettype none
module uogc_top
    import uogc_pkg::*;
#(
    parameter bit          CHARGER_SUPPORT = 1'b1,
    parameter bit          SLAVE_ONLY      = 1'b0,
    parameter logic [2:0]  OTG_BUILD_MODE  = 3'h0,
    parameter logic [1:0]  ULPI_BUILD      = 2'h2,
    parameter bit          IC_USB_CAPABLE  = 1'b1,
    parameter int          FORCE_CYCLES    = UOGC_FORCE_CYC
) (
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // PHY and link status pins (asynchronous)
    input  wire logic        b_session_valid,
    input  wire logic        charger_pin_change,
    input  wire logic        connect_debounce_done,
    input  wire logic        a_role_connect_timeout,
    input  wire logic        role_swap_request_seen,
    input  wire logic        role_swap_done,
    input  wire logic        role_swap_ok_in,
    input  wire logic        session_request_done,
    input  wire logic        session_request_ok_in,
    input  wire logic        id_pin,
    // Core-side FIFO and interrupt sources
    input  wire logic        core_irq_pending,
    input  wire logic        periodic_half_empty,
    input  wire logic        periodic_full_empty,
    input  wire logic        nonperiodic_half_empty,
    input  wire logic        nonperiodic_full_empty,
    output logic             periodic_fifo_empty_irq,
    output logic             nonperiodic_fifo_empty_irq,
    output logic             irq_out,
    // DMA write notification
    input  wire logic        dma_write_start,
    input  wire logic        dma_write_last,
    input  wire logic [3:0]  dma_channel,
    input  wire logic        system_dma_done,
    output logic             dma_request,
    output logic             dma_done,
    output logic             dma_last_transaction,
    output logic      [3:0]  dma_channel_number,
    output logic             transfer_complete_flag,
    output logic      [3:0]  dma_burst,
    output logic             dma_mode_out,
    // PHY control
    output logic             host_role,
    output logic             pull_detach_on_traffic,
    output logic             vbus_indicator_invert,
    output logic             pulse_source_select,
    output logic             external_vbus_comparator_sel
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    localparam int NPIN = 10;
    logic [NPIN-1:0] pin_s;

    uogc_sync #(.W(NPIN)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .d_async ({id_pin, session_request_ok_in, session_request_done, role_swap_ok_in,
                   role_swap_done, role_swap_request_seen, a_role_connect_timeout,
                   connect_debounce_done, charger_pin_change, b_session_valid}),
        .q_sync  (pin_s)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]       events;
        logic [31:0]       bus_cfg;
        logic [31:0]       link_cfg;
        logic              session_request_ok;
        logic              role_swap_ok;
        logic [NPIN-1:0]   pin_d;
        logic              host_role;
        logic [31:0]       force_cnt;
        uogc_dma_state_t   dma_st;
        logic              dma_last;
        logic [3:0]        dma_chan;
        logic              xfer_done;
        logic              dma_done;
        logic [31:0]       rdata;
    } uogc_state_t;

    uogc_state_t st_r;
    uogc_state_t st_nxt;

    // Shared decode: register write hit
    function automatic logic wr_hit(input logic [11:0] ofs);
        return reg_wr && (reg_addr == ofs);
    endfunction

    logic [31:0] ev_set;
    logic [NPIN-1:0] rise;
    logic        cap_en;
    logic        force_ok;
    logic        notify;

    always_comb begin
        st_nxt   = st_r;
        rise     = pin_s & ~st_r.pin_d;
        cap_en   = st_r.link_cfg[UOGC_HNP_CAP_BIT] | st_r.link_cfg[UOGC_SRP_CAP_BIT];
        force_ok = OTG_BUILD_MODE <= 3'h2;
        ev_set   = '0;
        notify   = 1'b0;
        st_nxt.pin_d     = pin_s;
        st_nxt.xfer_done = 1'b0;
        st_nxt.dma_done  = 1'b0;

        // Event sources
        ev_set[UOGC_EV_CHARGER]   = rise[1] & CHARGER_SUPPORT;
        ev_set[UOGC_EV_DEBOUNCE]  = rise[2] & cap_en;
        ev_set[UOGC_EV_A_TIMEOUT] = rise[3];
        ev_set[UOGC_EV_SWAP_SEEN] = rise[4];
        ev_set[UOGC_EV_SWAP_RES]  = rise[5];
        ev_set[UOGC_EV_SESS_RES]  = rise[7];
        ev_set[UOGC_EV_SESS_END]  = st_r.pin_d[0] & ~pin_s[0];
        if (rise[7]) begin
            st_nxt.session_request_ok = pin_s[8];
        end
        if (rise[5]) begin
            st_nxt.role_swap_ok = pin_s[6];
        end

        // Register writes; set wins over a same-cycle clear
        if (wr_hit(UOGC_EVENT_OFS)) begin
            st_nxt.events = st_r.events & ~reg_wdata;
        end
        st_nxt.events = (st_nxt.events | ev_set) & UOGC_EVENT_MASK;
        if (wr_hit(UOGC_BUS_CFG_OFS)) begin
            st_nxt.bus_cfg = reg_wdata & UOGC_BUS_MASK;
            if (SLAVE_ONLY) begin
                st_nxt.bus_cfg[UOGC_DMA_BIT] = 1'b0;
            end
        end
        if (wr_hit(UOGC_LINK_CFG_OFS)) begin
            st_nxt.link_cfg = reg_wdata & UOGC_LINK_MASK;
            if (!force_ok) begin
                st_nxt.link_cfg[UOGC_FORCE_DEV_BIT]  = 1'b0;
                st_nxt.link_cfg[UOGC_FORCE_HOST_BIT] = 1'b0;
            end
            if (ULPI_BUILD < 2'h2) begin
                st_nxt.link_cfg[UOGC_EXT_CMP_BIT] = 1'b0;
            end
            st_nxt.force_cnt = '0;
        end

        // Role change settles after the force delay
        if (st_r.force_cnt < FORCE_CYCLES) begin
            st_nxt.force_cnt = st_r.force_cnt + 32'h1;
        end else if (st_r.link_cfg[UOGC_FORCE_DEV_BIT]) begin
            st_nxt.host_role = 1'b0;
        end else if (st_r.link_cfg[UOGC_FORCE_HOST_BIT]) begin
            st_nxt.host_role = 1'b1;
        end else begin
            st_nxt.host_role = ~pin_s[9];
        end

        // DMA write notification handshake
        notify = st_r.bus_cfg[UOGC_NOTIFY_BIT] | dma_write_last;
        case (st_r.dma_st)
            UOGC_DMA_IDLE: begin
                if (dma_write_start) begin
                    if (st_r.bus_cfg[UOGC_REMOTE_BIT] && notify) begin
                        st_nxt.dma_st   = UOGC_DMA_REQ;
                        st_nxt.dma_last = dma_write_last;
                        st_nxt.dma_chan = dma_channel;
                    end else begin
                        st_nxt.xfer_done = 1'b1;
                    end
                end
            end
            UOGC_DMA_REQ: begin
                st_nxt.dma_done = 1'b1;
                st_nxt.dma_st   = UOGC_DMA_WAIT;
            end
            UOGC_DMA_WAIT: begin
                if (system_dma_done) begin
                    st_nxt.xfer_done = 1'b1;
                    st_nxt.dma_st    = UOGC_DMA_IDLE;
                end
            end
            default: begin
                st_nxt.dma_st = UOGC_DMA_IDLE;
            end
        endcase

        // Read data valid in the cycle after the strobe; unmapped reads zero
        st_nxt.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == UOGC_OTG_CTL_OFS) begin
                st_nxt.rdata[UOGC_SESS_OK_BIT] = st_r.session_request_ok;
                st_nxt.rdata[UOGC_SWAP_OK_BIT] = st_r.role_swap_ok;
            end else if (reg_addr == UOGC_EVENT_OFS) begin
                st_nxt.rdata = st_r.events;
            end else if (reg_addr == UOGC_BUS_CFG_OFS) begin
                st_nxt.rdata = st_r.bus_cfg;
            end else if (reg_addr == UOGC_LINK_CFG_OFS) begin
                st_nxt.rdata = st_r.link_cfg;
            end else if (reg_addr == UOGC_PHY_EVT_OFS) begin
                st_nxt.rdata[NPIN-1:0] = pin_s;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r        <= '0;
            st_r.dma_st <= UOGC_DMA_IDLE;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic dma_on;
    assign dma_on = st_r.bus_cfg[UOGC_DMA_BIT];

    assign reg_rdata = st_r.rdata;
    // Status keeps updating; only the line is gated
    assign irq_out = core_irq_pending & st_r.bus_cfg[UOGC_UNMASK_BIT];
    // FIFO triggers only meaningful in slave mode
    assign periodic_fifo_empty_irq = ~dma_on & (st_r.bus_cfg[UOGC_PER_LVL_BIT]
        ? periodic_full_empty : periodic_half_empty);
    assign nonperiodic_fifo_empty_irq = ~dma_on & (st_r.bus_cfg[UOGC_NPER_LVL_BIT]
        ? nonperiodic_full_empty : nonperiodic_half_empty);
    // Reserved codes pass unchanged; software must not use them
    assign dma_burst = st_r.bus_cfg[UOGC_BURST_LSB +: 4];
    assign dma_mode_out = dma_on;
    assign dma_request = (st_r.dma_st == UOGC_DMA_REQ);
    assign dma_done = st_r.dma_done;
    assign dma_last_transaction = st_r.dma_last;
    assign dma_channel_number = st_r.dma_chan;
    assign transfer_complete_flag = st_r.xfer_done;
    assign host_role = st_r.host_role;
    assign pull_detach_on_traffic = st_r.link_cfg[UOGC_PULL_DET_BIT] & IC_USB_CAPABLE;
    assign vbus_indicator_invert = st_r.link_cfg[UOGC_VBUS_INV_BIT];
    assign pulse_source_select = st_r.link_cfg[UOGC_PULSE_SEL_BIT];
    assign external_vbus_comparator_sel = st_r.link_cfg[UOGC_EXT_CMP_BIT];
endmodule
`default_nettype wire

// ### uogc_checker.sv
// Checker for uogc_top: config outputs, FIFO triggers, irq gate, DMA notification.
// Assumes it is bound into uogc_top with default build parameters.
`default_nettype none
module uogc_checker
    import uogc_pkg::*;
(
    // Clock and register writes
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    // Interrupt sources and lines
    input wire logic        core_irq_pending,
    input wire logic        periodic_half_empty,
    input wire logic        periodic_full_empty,
    input wire logic        nonperiodic_half_empty,
    input wire logic        nonperiodic_full_empty,
    input wire logic        periodic_fifo_empty_irq,
    input wire logic        nonperiodic_fifo_empty_irq,
    input wire logic        irq_out,
    // DMA notification
    input wire logic        dma_write_start,
    input wire logic        dma_write_last,
    input wire logic [3:0]  dma_channel,
    input wire logic        dma_request,
    input wire logic        dma_done,
    input wire logic [3:0]  dma_channel_number,
    input wire logic        transfer_complete_flag,
    // Configuration outputs
    input wire logic [3:0]  dma_burst,
    input wire logic        dma_mode_out,
    input wire logic        pull_detach_on_traffic,
    input wire logic        vbus_indicator_invert,
    input wire logic        pulse_source_select,
    input wire logic        external_vbus_comparator_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Shadow registers; updated on the same edge as the design's copies
    logic [31:0] bus_r;
    logic [31:0] link_r;
    logic        hs_need;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bus_r  <= 32'h0000_0000;
            link_r <= 32'h0000_0000;
        end else if (clk_en && reg_wr && reg_addr == UOGC_BUS_CFG_OFS) begin
            bus_r <= reg_wdata;
        end else if (clk_en && reg_wr && reg_addr == UOGC_LINK_CFG_OFS) begin
            link_r <= reg_wdata;
        end
    end
    assign hs_need = bus_r[21] & (bus_r[22] | dma_write_last);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence req_then_done;
        dma_request ##1 dma_done;
    endsequence
    sequence done_at_once;
        transfer_complete_flag && !dma_request;
    endsequence
    irq_gate_a: assert property (irq_out == (core_irq_pending & bus_r[0]))
        else $error("irq line not gated by unmask");
    per_level_a: assert property (periodic_fifo_empty_irq == (!bus_r[5]
        && (bus_r[8] ? periodic_full_empty : periodic_half_empty)))
        else $error("periodic empty trigger wrong");
    nper_level_a: assert property (nonperiodic_fifo_empty_irq == (!bus_r[5]
        && (bus_r[7] ? nonperiodic_full_empty : nonperiodic_half_empty)))
        else $error("nonperiodic empty trigger wrong");
    burst_out_a: assert property (dma_burst == bus_r[4:1])
        else $error("burst output differs from field");
    dma_mode_a: assert property (dma_mode_out == bus_r[5])
        else $error("dma mode output wrong");
    pull_detach_a: assert property (pull_detach_on_traffic == link_r[27])
        else $error("pull detach output wrong");
    vbus_invert_a: assert property (vbus_indicator_invert == link_r[23])
        else $error("vbus invert output wrong");
    pulse_select_a: assert property (pulse_source_select == link_r[22])
        else $error("pulse source output wrong");
    ext_compare_a: assert property (external_vbus_comparator_sel == link_r[21])
        else $error("comparator select output wrong");
    notify_write_a: assert property (dma_write_start && hs_need |=> req_then_done)
        else $error("request and done not raised");
    skip_wait_a: assert property (dma_write_start && !hs_need |=> done_at_once)
        else $error("completion not immediate");
    // Channel is only captured when a request is actually raised
    channel_hold_a: assert property (dma_write_start && hs_need |=>
        dma_channel_number == $past(dma_channel))
        else $error("channel number not captured");
endmodule
`default_nettype wire

// ### uogc_phy_model.sv
// Behavioural PHY presenting status pins to the block.
// Assumes the bench requests levels; pins move only on link clock edges.
`default_nettype none
module uogc_phy_model (
    // Link clock
    input  wire logic       link_clk,
    // Requested and presented pin levels
    input  wire logic [9:0] pin_cmd,
    output var  logic [9:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] cur_r  = 10'h000;
    logic [9:0] prev_r = 10'h000;
    // Done pins lag one link edge so ok levels are settled first
    // Session valid and event pins follow the request directly
    always @(posedge link_clk) begin
        cur_r  <= pin_cmd;
        prev_r <= cur_r;
    end
    assign pins = {cur_r[9:8], prev_r[7], cur_r[6], prev_r[5], cur_r[4:0]};
endmodule
`default_nettype wire

// ### test_usb_otg_global_config_intr.sv
// Self-checking bench for uogc_top with a behavioural PHY and bound checker.
// Assumes 20 MHz ref_clk, 400 ns link clock and a shortened force wait.
`default_nettype none
module test_usb_otg_global_config_intr
    import uogc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FORCE_N = 20;
    logic ref_clk = 1'b0, link_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [9:0] pin_cmd = 10'h200, pins;
    logic b_session_valid, charger_pin_change, connect_debounce_done, a_role_connect_timeout;
    logic role_swap_request_seen, role_swap_done, role_swap_ok_in, session_request_done;
    logic session_request_ok_in, id_pin, core_irq_pending = 1'b0;
    logic periodic_half_empty = 1'b0, periodic_full_empty = 1'b0;
    logic nonperiodic_half_empty = 1'b0, nonperiodic_full_empty = 1'b0;
    logic dma_write_start = 1'b0, dma_write_last = 1'b0, system_dma_done = 1'b0;
    logic [3:0] dma_channel = 4'h0, dma_channel_number, dma_burst;
    logic periodic_fifo_empty_irq, nonperiodic_fifo_empty_irq, irq_out, dma_request;
    logic dma_done, dma_last_transaction, transfer_complete_flag, dma_mode_out, host_role;
    logic pull_detach_on_traffic, vbus_indicator_invert, pulse_source_select;
    logic external_vbus_comparator_sel;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // Last and channel seen by the last write that raised a request
    logic [4:0] dma_q = 5'h00;
    assign {id_pin, session_request_ok_in, session_request_done, role_swap_ok_in,
            role_swap_done, role_swap_request_seen, a_role_connect_timeout,
            connect_debounce_done, charger_pin_change, b_session_valid} = pins;
    uogc_top #(.FORCE_CYCLES(FORCE_N)) DUT (.*);
    uogc_phy_model PHY (.link_clk(link_clk), .pin_cmd(pin_cmd), .pins(pins));
    initial forever #25 ref_clk = ~ref_clk;
    initial forever #200 link_clk = ~link_clk;
    // Hang guard: the sequence needs about 600 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_reset();
        rd(UOGC_OTG_CTL_OFS, 32'h0000_0000);
        rd(UOGC_EVENT_OFS, 32'h0000_0000);
        rd(UOGC_BUS_CFG_OFS, 32'h0000_0000);
        rd(UOGC_LINK_CFG_OFS, 32'h0000_0000);
        rd(12'h040, 32'h0000_0000);
    endtask
    task automatic t_cfg();
        logic [31:0] w;
        for (int c = 0; c < 8; c++) begin
            w = 32'hFF80_0000 | (32'(c) << 1) | (32'(c[0]) << 8) | (32'(c[1]) << 7);
            w = w | (32'(c[2]) << 5) | 32'(c[0]);
            {core_irq_pending, periodic_half_empty, periodic_full_empty} <= {1'b1, c[1:0]};
            {nonperiodic_half_empty, nonperiodic_full_empty} <= c[2:1];
            wr(UOGC_BUS_CFG_OFS, w);
            rd(UOGC_BUS_CFG_OFS, w & 32'h0000_01BF);
            chk(dma_burst, c[3:0]);
            chk(dma_mode_out, c[2]);
            chk(irq_out, c[0]);
        end
    endtask
    task automatic dma(input logic lst, input logic [3:0] ch, input logic hs, input int slow);
        @(posedge ref_clk);
        dma_write_start <= 1'b1;
        dma_write_last  <= lst;
        dma_channel     <= ch;
        @(posedge ref_clk);
        dma_write_start <= 1'b0;
        if (hs) begin
            dma_q = {lst, ch};
            pause(1 + slow);
            chk(transfer_complete_flag, 1'b0);
            @(posedge ref_clk);
            system_dma_done <= 1'b1;
            @(posedge ref_clk);
            system_dma_done <= 1'b0;
        end
        #1;
        chk(transfer_complete_flag, 1'b1);
        chk(dma_channel_number, dma_q[3:0]);
        chk(dma_last_transaction, dma_q[4]);
        @(posedge ref_clk);
    endtask
    task automatic t_dma();
        wr(UOGC_BUS_CFG_OFS, 32'h0020_0020);
        dma(1'b0, 4'h3, 1'b0, 0);
        dma(1'b1, 4'h5, 1'b1, 0);
        wr(UOGC_BUS_CFG_OFS, 32'h0060_0020);
        dma(1'b0, 4'hA, 1'b1, 3);
        wr(UOGC_BUS_CFG_OFS, 32'h0040_0020);
        dma(1'b1, 4'hF, 1'b0, 0);
    endtask
    task automatic t_events();
        int pin_of [6] = '{1, 2, 3, 4, 5, 7};
        int bit_of [6] = '{20, 19, 18, 17, 9, 8};
        logic [31:0] m;
        wr(UOGC_LINK_CFG_OFS, 32'h0000_0100);
        pin_cmd = 10'h341;
        pause(40);
        for (int i = 0; i < 6; i++) begin
            m = 32'h1 << bit_of[i];
            pin_cmd[pin_of[i]] = 1'b1;
            pause(40);
            rd(UOGC_EVENT_OFS, m);
            wr(UOGC_EVENT_OFS, ~m);
            rd(UOGC_EVENT_OFS, m);
            wr(UOGC_EVENT_OFS, m);
            rd(UOGC_EVENT_OFS, 32'h0000_0000);
            pin_cmd[pin_of[i]] = 1'b0;
        end
        rd(UOGC_OTG_CTL_OFS, 32'h0000_0101);
        pin_cmd = 10'h2A1;
        pause(40);
        rd(UOGC_OTG_CTL_OFS, 32'h0000_0000);
        rd(UOGC_EVENT_OFS, 32'h0000_0300);
        wr(UOGC_EVENT_OFS, 32'h0000_0300);
        pin_cmd = 10'h200;
        pause(40);
        rd(UOGC_EVENT_OFS, 32'h0000_0004);
        wr(UOGC_EVENT_OFS, 32'h0000_0004);
        wr(UOGC_LINK_CFG_OFS, 32'h0000_0000);
        pin_cmd = 10'h204;
        pause(40);
        rd(UOGC_EVENT_OFS, 32'h0000_0000);
    endtask
    task automatic t_force();
        chk(host_role, 1'b0);
        wr(UOGC_LINK_CFG_OFS, 32'hBFFF_FFFF);
        pause(5);
        chk(host_role, 1'b0);
        pause(FORCE_N);
        chk(host_role, 1'b1);
        rd(UOGC_LINK_CFG_OFS, 32'h28E0_0300);
        wr(UOGC_LINK_CFG_OFS, 32'hFFFF_FFFF);
        pause(FORCE_N + 5);
        chk(host_role, 1'b0);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_cfg();
        t_dma();
        t_events();
        t_force();
        conclude();
    end
endmodule
bind uogc_top uogc_checker u_chk (.*);
`default_nettype wire
